/* File: hw/adcfs_pkg.sv */
// Shared constants, types and carriers of the frame-sync converter port
package adcfs_pkg;

    // Result, channel and count widths
    localparam int RES_BITS = 16;
    localparam int CHAN_W = 3;
    localparam int CNT_W = 6;

    typedef logic [RES_BITS-1:0] adcfs_word_t;
    typedef logic [CHAN_W-1:0] adcfs_chan_t;
    typedef logic [CNT_W-1:0] adcfs_cnt_t;
    typedef logic [3:0] adcfs_idx_t;

    // Serial-clock counts within one frame
    localparam adcfs_cnt_t CNT_ZERO = 6'h00;
    localparam adcfs_cnt_t CNT_ONE = 6'h01;
    localparam adcfs_cnt_t CNT_MAX = 6'h3f;
    localparam adcfs_cnt_t CMD_N_NARROW = 6'h08;
    localparam adcfs_cnt_t CMD_N_WIDE = 6'h10;
    localparam adcfs_cnt_t CHAN_CLK = 6'h03;
    localparam adcfs_cnt_t SAMPLE_NARROW = 6'h07;
    localparam adcfs_cnt_t SAMPLE_WIDE = 6'h0f;
    localparam adcfs_cnt_t RESULT_LEN = 6'h10;
    localparam adcfs_idx_t RES_MSB = 4'hf;

    // Link-side state, one-hot
    typedef enum logic [3:0] {
        ST_OFF = 4'h1,
        ST_SPI = 4'h2,
        ST_WAIT = 4'h4,
        ST_FRAME = 4'h8
    } adcfs_state_e;

    // Falling-edge group: command capture and framing
    typedef struct packed {
        adcfs_state_e state;
        adcfs_cnt_t cnt;
        logic wide;
        adcfs_word_t cmd;
        adcfs_word_t cmd_word;
        adcfs_chan_t chan;
        logic wake;
    } adcfs_neg_s;

    // Rising-edge group: sampling and result shifting
    typedef struct packed {
        logic dout;
        logic dout_oe_n;
        logic fso;
        logic sample;
        adcfs_word_t result;
    } adcfs_pos_s;

    localparam adcfs_neg_s NEG_RST = '{state: ST_OFF, cnt: CNT_ZERO, wide: 1'b0,
        cmd: 16'h0000, cmd_word: 16'h0000, chan: 3'h0, wake: 1'b0};
    localparam adcfs_pos_s POS_RST = '{dout: 1'b0, dout_oe_n: 1'b1, fso: 1'b0,
        sample: 1'b0, result: 16'h0000};

endpackage

/* File: hw/adcfs_port.sv */
// Frame-sync serial port of the converter, link logic on the serial clock
`timescale 1ns/1ps
module adcfs_port (
    input wire logic clk,
    input wire logic rst_n,
    input wire adcfs_pkg::adcfs_word_t code_in,
    input wire logic code_valid,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic frame_sync_in,
    input wire logic transfer_width_select,
    input wire logic din,
    output logic dout,
    output logic dout_oe_n,
    output logic frame_sync_out,
    output adcfs_pkg::adcfs_chan_t channel_sel,
    output logic sample_strobe,
    output logic analog_wake,
    output adcfs_pkg::adcfs_word_t command_word
);
    import adcfs_pkg::*;

    // Reset brought into the serial-clock domain
    logic rst_s1_q, rst_s2_q;
    logic link_rst_n;
    // Falling-edge and rising-edge state groups
    adcfs_neg_s neg_q, neg_d;
    adcfs_pos_s pos_q, pos_d;
    // Latest converter code, already in the serial-clock domain
    adcfs_word_t latest_code;
    // Frame geometry for the width latched at frame start
    adcfs_cnt_t cnt_nx;
    adcfs_cnt_t n_len;
    adcfs_cnt_t s_clk;
    adcfs_cnt_t end_c;
    adcfs_cnt_t off_c;
    adcfs_idx_t bit_idx;
    logic in_frame;

    // Command length for one width
    function automatic adcfs_cnt_t frame_len(input logic wide);
        frame_len = wide ? CMD_N_WIDE : CMD_N_NARROW;
    endfunction

    // Clock whose rising edge ends acquisition
    function automatic adcfs_cnt_t sample_clk(input logic wide);
        sample_clk = wide ? SAMPLE_WIDE : SAMPLE_NARROW;
    endfunction

    // Converter code word crossing; the core keeps converting the chosen input
    adcfs_word_cdc u_cdc (
        .clk(clk),
        .rst_n(rst_n),
        .src_data(code_in),
        .src_valid(code_valid),
        .dst_clk(sclk),
        .dst_rst_n(link_rst_n),
        .dst_data(latest_code)
    );

    // Reset level synchroniser; takes effect only while the serial clock runs
    always_ff @(posedge sclk) begin
        rst_s1_q <= rst_n;
        rst_s2_q <= rst_s1_q;
    end
    assign link_rst_n = rst_s2_q;

    // Frame geometry
    assign cnt_nx = neg_q.cnt + CNT_ONE;
    assign n_len = frame_len(neg_q.wide);
    assign s_clk = sample_clk(neg_q.wide);
    assign end_c = n_len + RESULT_LEN;
    assign off_c = neg_q.cnt - n_len;
    assign bit_idx = RES_MSB - off_c[3:0];
    assign in_frame = (neg_q.state == ST_FRAME);

    // Falling-edge next state: mode entry, framing, command capture
    always_comb begin
        neg_d = neg_q;
        if (cs_n) begin
            neg_d.state = ST_OFF;
            neg_d.cnt = CNT_ZERO;
            neg_d.wake = 1'b0;
        end else begin
            unique case (neg_q.state)
                ST_OFF: begin
                    // mode chosen by sync level at select fall
                    // sync high leaves the port idle here
                    neg_d.state = frame_sync_in ? ST_SPI : ST_WAIT;
                end
                ST_SPI: begin
                    // Other interface is not served by this block
                    neg_d.state = ST_SPI;
                end
                ST_WAIT, ST_FRAME: begin
                    // select held low, frames follow each other
                    if (frame_sync_in) begin
                        // sync pulse restarts any frame in flight
                        neg_d.state = ST_FRAME;
                        neg_d.cnt = CNT_ZERO;
                        neg_d.wake = 1'b1;
                        neg_d.wide = transfer_width_select;
                        neg_d.cmd = 16'h0000;
                    end else if (in_frame && neg_q.cnt != CNT_MAX) begin
                        // Count clocks, saturating past the frame end
                        neg_d.cnt = cnt_nx;
                        // bits 1 through the command length
                        if (neg_q.cnt < n_len) begin
                            neg_d.cmd = {neg_q.cmd[RES_BITS-2:0], din};
                        end
                        // Whole command published at its last bit
                        if (cnt_nx == n_len) begin
                            neg_d.cmd_word = {neg_q.cmd[RES_BITS-2:0], din};
                        end
                        // channel from the first three command bits
                        if (cnt_nx == CHAN_CLK) begin
                            neg_d.chan = {neg_q.cmd[CHAN_W-2:0], din};
                        end
                    end
                end
                default: begin
                    // Illegal one-hot code falls back to shutdown
                    neg_d = NEG_RST;
                end
            endcase
        end
    end

    // Falling-edge registers
    always_ff @(negedge sclk) begin
        if (!link_rst_n) begin
            neg_q <= NEG_RST;
        end else begin
            neg_q <= neg_d;
        end
    end

    // Rising-edge next state: sample, output sync, result shift
    always_comb begin
        pos_d = pos_q;
        pos_d.fso = 1'b0;
        pos_d.sample = 1'b0;
        pos_d.dout = 1'b0;
        // output floats while shut down, drives low once selected
        pos_d.dout_oe_n = (neg_q.state == ST_OFF);
        if (in_frame) begin
            // acquisition ends, input held on this rising edge
            // code kept as plain unsigned binary
            if (cnt_nx == s_clk) begin
                pos_d.sample = 1'b1;
                pos_d.result = latest_code;
            end
            // sync out on the command's last rising edge
            // cleared again on the next rising edge
            if (cnt_nx == n_len) begin
                pos_d.fso = 1'b1;
            end
            // sixteen bits MSB first, zeros after them
            if (neg_q.cnt >= n_len && neg_q.cnt < end_c) begin
                pos_d.dout = pos_q.result[bit_idx];
            end
        end
    end

    // Rising-edge registers
    always_ff @(posedge sclk) begin
        if (!link_rst_n) begin
            pos_q <= POS_RST;
        end else begin
            pos_q <= pos_d;
        end
    end

    // Outputs straight from the flops
    assign dout = pos_q.dout;
    assign dout_oe_n = pos_q.dout_oe_n;
    assign frame_sync_out = pos_q.fso;
    assign sample_strobe = pos_q.sample;
    assign channel_sel = neg_q.chan;
    assign analog_wake = neg_q.wake;
    assign command_word = neg_q.cmd_word;

    // Select high always ends in shutdown
    a_cs_shutdown: assert property (@(negedge sclk) disable iff (!link_rst_n)
        cs_n |=> (neg_q.state == ST_OFF) && !analog_wake)
        else $error("select high did not shut the port down");

    // Sync low at select fall enters frame mode
    a_mode_entry: assert property (@(negedge sclk) disable iff (!link_rst_n)
        (neg_q.state == ST_OFF) && !cs_n && !frame_sync_in |=> neg_q.state == ST_WAIT)
        else $error("frame mode not entered at select fall");

    // Sync pulse restarts a frame with the pin width
    a_frame_restart: assert property (@(negedge sclk) disable iff (!link_rst_n)
        (neg_q.state == ST_WAIT || in_frame) && !cs_n && frame_sync_in
        |=> in_frame && neg_q.cnt == CNT_ZERO && analog_wake
            && neg_q.wide == $past(transfer_width_select))
        else $error("sync pulse did not restart the frame");

    // Channel taken at the third falling edge
    a_chan_pick: assert property (@(negedge sclk) disable iff (!link_rst_n)
        in_frame && !cs_n && !frame_sync_in && cnt_nx == CHAN_CLK
        |=> channel_sel == {$past(neg_q.cmd[CHAN_W-2:0]), $past(din)})
        else $error("channel not taken at third clock");

    // Narrow command complete at the eighth falling edge
    a_cmd_narrow: assert property (@(negedge sclk) disable iff (!link_rst_n)
        in_frame && !neg_q.wide && !cs_n && !frame_sync_in && cnt_nx == CMD_N_NARROW
        |=> command_word[7:0] == {$past(neg_q.cmd[6:0]), $past(din)})
        else $error("narrow command word wrong");

    // Wide command complete at the sixteenth falling edge
    a_cmd_wide: assert property (@(negedge sclk) disable iff (!link_rst_n)
        in_frame && neg_q.wide && !cs_n && !frame_sync_in && cnt_nx == CMD_N_WIDE
        |=> command_word == {$past(neg_q.cmd[RES_BITS-2:0]), $past(din)})
        else $error("wide command word wrong");

    // Sample pulse only after the sample clock's rising edge
    a_sample_time: assert property (@(posedge sclk) disable iff (!link_rst_n)
        sample_strobe && in_frame |-> neg_q.cnt == s_clk)
        else $error("sample at wrong clock");

    // Output sync marks the command's last clock
    a_fso_place: assert property (@(posedge sclk) disable iff (!link_rst_n)
        frame_sync_out && in_frame |-> neg_q.cnt == n_len)
        else $error("output sync at wrong clock");

    // Output sync is one clock wide
    a_fso_width: assert property (@(posedge sclk) disable iff (!link_rst_n)
        $rose(frame_sync_out) |=> !frame_sync_out)
        else $error("output sync longer than one clock");

    // First result bit is the MSB
    a_msb_first: assert property (@(posedge sclk) disable iff (!link_rst_n)
        in_frame && neg_q.cnt == n_len + CNT_ONE |-> dout == pos_q.result[RES_MSB])
        else $error("result not MSB first");

    // Clocks past the result give zeros
    a_zero_tail: assert property (@(posedge sclk) disable iff (!link_rst_n)
        in_frame && neg_q.cnt > end_c |-> !dout)
        else $error("nonzero bit after the result");

    // Output driven low just after select falls into frame mode
    a_oe_driven: assert property (@(posedge sclk) disable iff (!link_rst_n)
        neg_q.state == ST_OFF ##1 neg_q.state == ST_WAIT |=> !dout_oe_n && !dout)
        else $error("output not driven low after select");

    // Count parks at its ceiling, so a long tail never wraps into a second result
    a_cnt_park: assert property (@(negedge sclk) disable iff (!link_rst_n)
        in_frame && !cs_n && !frame_sync_in && neg_q.cnt == CNT_MAX |=> neg_q.cnt == CNT_MAX)
        else $error("clock count left its ceiling");

    // Command word moves only at the command's last falling edge
    a_cmd_stable: assert property (@(negedge sclk) disable iff (!link_rst_n)
        !(in_frame && !cs_n && !frame_sync_in && cnt_nx == n_len) |=> $stable(command_word))
        else $error("command word moved outside its last clock");

    // Channel moves only at the third falling edge
    a_chan_stable: assert property (@(negedge sclk) disable iff (!link_rst_n)
        !(in_frame && !cs_n && !frame_sync_in && cnt_nx == CHAN_CLK) |=> $stable(channel_sel))
        else $error("channel moved outside the third clock");

    // Shutdown drops the wake request
    a_wake_off: assert property (@(negedge sclk) disable iff (!link_rst_n)
        neg_q.state == ST_OFF |-> !analog_wake)
        else $error("analog side awake while shut down");

    // Sample pulse is one clock wide
    a_strobe_width: assert property (@(posedge sclk) disable iff (!link_rst_n)
        $rose(sample_strobe) |=> !sample_strobe)
        else $error("sample pulse longer than one clock");

    // Shutdown floats the data output on the next rising edge
    a_oe_float: assert property (@(posedge sclk) disable iff (!link_rst_n)
        neg_q.state == ST_OFF |=> dout_oe_n)
        else $error("output still driven in shutdown");

    // Outside a frame the data line stays low
    a_dout_quiet: assert property (@(posedge sclk) disable iff (!link_rst_n)
        !in_frame |=> !dout)
        else $error("data bit outside a frame");

endmodule

/* File: hw/adcfs_word_cdc.sv */
// Handshake crossing of the converter code word into the serial-clock domain
`timescale 1ns/1ps
module adcfs_word_cdc (
    input wire logic clk,
    input wire logic rst_n,
    input wire adcfs_pkg::adcfs_word_t src_data,
    input wire logic src_valid,
    input wire logic dst_clk,
    input wire logic dst_rst_n,
    output adcfs_pkg::adcfs_word_t dst_data
);
    import adcfs_pkg::*;

    // Source side: held word and request toggle
    adcfs_word_t hold_q, hold_d;
    logic req_q, req_d;
    logic ack_s1_q, ack_s2_q;
    // Destination side: request synchroniser, ack toggle, copy
    logic req_s1_q, req_s2_q;
    logic ack_q, ack_d;
    adcfs_word_t data_q, data_d;
    logic busy;

    // Busy while the far side has not yet answered
    assign busy = req_q ^ ack_s2_q;

    // Source next state; codes offered while busy are dropped, the next one offered when idle is taken
    always_comb begin
        hold_d = hold_q;
        req_d = req_q;
        if (src_valid && !busy) begin
            hold_d = src_data;
            req_d = ~req_q;
        end
    end

    // Source registers, ack brought back over two flops
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hold_q <= 16'h0000;
            req_q <= 1'b0;
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
        end else begin
            hold_q <= hold_d;
            req_q <= req_d;
            ack_s1_q <= ack_q;
            ack_s2_q <= ack_s1_q;
        end
    end

    // Destination next state; held word is stable while the toggles differ
    always_comb begin
        ack_d = ack_q;
        data_d = data_q;
        if (req_s2_q != ack_q) begin
            data_d = hold_q;
            ack_d = ~ack_q;
        end
    end

    // Destination registers; only runs while the serial clock runs
    always_ff @(posedge dst_clk) begin
        if (!dst_rst_n) begin
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
            ack_q <= 1'b0;
            data_q <= 16'h0000;
        end else begin
            req_s1_q <= req_q;
            req_s2_q <= req_s1_q;
            ack_q <= ack_d;
            data_q <= data_d;
        end
    end

    assign dst_data = data_q;

    // Held word must not move during a handshake
    a_hold_stable: assert property (@(posedge clk) disable iff (!rst_n)
        busy |=> $stable(hold_q))
        else $error("held code word changed while crossing");

endmodule

/* File: tb/adc_dsp_frame_sync_port_tb_top.sv */
// Self-checking bench of the frame-sync converter port
`timescale 1ns/1ps
module adc_dsp_frame_sync_port_tb_top;
    import adcfs_pkg::*;

    logic clk;
    logic rst_n;
    adcfs_word_t code_in;
    logic code_valid;
    logic sclk, cs_n, frame_sync_in, transfer_width_select, din;
    logic dout, dout_oe_n, frame_sync_out, sample_strobe, analog_wake;
    adcfs_chan_t channel_sel;
    adcfs_word_t command_word;
    int checks = 0;
    int n_mismatch = 0;

    // Core clock, 4 ns period
    always #2 clk = ~clk;

    adcfs_port i_dut (.clk(clk), .rst_n(rst_n), .code_in(code_in), .code_valid(code_valid),
        .sclk(sclk), .cs_n(cs_n), .frame_sync_in(frame_sync_in),
        .transfer_width_select(transfer_width_select), .din(din), .dout(dout),
        .dout_oe_n(dout_oe_n), .frame_sync_out(frame_sync_out), .channel_sel(channel_sel),
        .sample_strobe(sample_strobe), .analog_wake(analog_wake), .command_word(command_word));

    // Far-side master owns the serial clock and all link inputs
    adcfs_dsp_master i_mst (.sclk(sclk), .cs_n(cs_n), .frame_sync_in(frame_sync_in),
        .transfer_width_select(transfer_width_select), .din(din), .dout(dout),
        .dout_oe_n(dout_oe_n), .frame_sync_out(frame_sync_out), .sample_strobe(sample_strobe));

    // One comparison; an unknown never matches
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Hand a code word to the crossing, one-cycle pulse
    task automatic give_code(input logic [15:0] w);
        @(posedge clk);
        #1 code_in = w;
        code_valid = 1'b1;
        @(posedge clk);
        #1 code_valid = 1'b0;
    endtask

    // Judge one recorded frame against the expected timing and data
    task automatic chk_frame(input logic w, input logic [15:0] cmd, input logic [15:0] code, input int n);
        int nn;
        nn = w ? 16 : 8;
        for (int k = 1; k <= n; k++) begin
            chk("sync_out", 16'(k == nn), 16'(i_mst.fso_v[k]));
            chk("strobe", 16'(k == nn - 1), 16'(i_mst.str_v[k]));
            chk("dout", 16'((k > nn && k <= nn + 16) ? code[nn+16-k] : 1'b0), 16'(i_mst.dat_v[k]));
            chk("oe_n", 16'h0000, 16'(i_mst.oe_v[k]));
        end
        chk("channel", 16'(cmd[nn-1 -: 3]), 16'(channel_sel));
        chk("command", w ? cmd : {8'h00, cmd[7:0]}, command_word);
        chk("wake", 16'h0001, 16'(analog_wake));
    endtask

    // Output floats until select falls; then frame mode is entered
    task automatic t_start();
        chk("oe_n idle", 16'h0001, 16'(dout_oe_n));
        i_mst.pulse(1'b0, 1'b0, 1'b0, 1'b0, -1);
        $display("test start done");
    endtask

    // Narrow then wide frame, back to back with select held low
    task automatic t_widths();
        give_code(16'hb38c);
        i_mst.frame(1'b0, 16'h00a5, 24);
        chk_frame(1'b0, 16'h00a5, 16'hb38c, 24);
        give_code(16'h4e17);
        i_mst.frame(1'b1, 16'h5c3a, 35);
        chk_frame(1'b1, 16'h5c3a, 16'h4e17, 35);
        $display("test widths done");
    endtask

    // Sync in mid-frame restarts the count from the new sync
    task automatic t_resync();
        give_code(16'h9a61);
        i_mst.frame(1'b1, 16'hffff, 10);
        i_mst.frame(1'b0, 16'h0042, 24);
        chk_frame(1'b0, 16'h0042, 16'h9a61, 24);
        // Long tail past the count ceiling: zeros only, no second result
        for (int k = 25; k <= 80; k++) begin
            i_mst.pulse(1'b0, 1'b0, 1'b0, 1'b0, -1);
            chk("tail dout", 16'h0000, 16'(dout));
        end
        $display("test resync done");
    endtask

    // Select rising mid-frame aborts, floats the output, sleeps
    task automatic t_cs_abort();
        i_mst.frame(1'b1, 16'h1234, 10);
        for (int k = 1; k <= 3; k++) begin
            i_mst.pulse(1'b1, 1'b0, 1'b0, 1'b0, k);
        end
        chk("oe_n abort", 16'h0001, 16'(i_mst.oe_v[3]));
        chk("sync abort", 16'h0000, 16'(i_mst.fso_v[3]));
        chk("wake abort", 16'h0000, 16'(analog_wake));
        $display("test cs_abort done");
    endtask

    // Sync high at select fall picks the other mode: no frame output
    task automatic t_other_mode();
        for (int k = 1; k <= 24; k++) begin
            i_mst.pulse(1'b0, 1'b1, k[0], 1'b0, k);
        end
        for (int k = 2; k <= 24; k++) begin
            chk("other sync", 16'h0000, 16'(i_mst.fso_v[k]));
            chk("other dout", 16'h0000, 16'(i_mst.dat_v[k]));
        end
        i_mst.pulse(1'b1, 1'b0, 1'b0, 1'b0, -1);
        i_mst.pulse(1'b0, 1'b0, 1'b0, 1'b0, -1);
        give_code(16'h0ff0);
        i_mst.frame(1'b1, 16'hc001, 32);
        chk_frame(1'b1, 16'hc001, 16'h0ff0, 32);
        $display("test other_mode done");
    endtask

    // Counts, verdict and end of run
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Main sequence; reset spans six link clocks so the link side sees it
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        code_in = 16'h0000;
        code_valid = 1'b0;
        repeat (6) i_mst.pulse(1'b1, 1'b0, 1'b0, 1'b0, -1);
        @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (3) i_mst.pulse(1'b1, 1'b0, 1'b0, 1'b0, -1);
        t_start();
        t_widths();
        t_resync();
        t_cs_abort();
        t_other_mode();
        report_and_stop();
    end

    // Watchdog, far beyond the 236 link clocks the tests need
    initial begin
        #100000;
        n_mismatch++;
        report_and_stop();
    end
endmodule

/* File: tb/adcfs_dsp_master.sv */
// Behavioural frame-sync master that drives the converter's serial port
`timescale 1ns/1ps
module adcfs_dsp_master (
    output logic sclk,
    output logic cs_n,
    output logic frame_sync_in,
    output logic transfer_width_select,
    output logic din,
    input wire logic dout,
    input wire logic dout_oe_n,
    input wire logic frame_sync_out,
    input wire logic sample_strobe
);
    // What the port showed after each rising edge, index = clock number
    logic fso_v [0:47];
    logic str_v [0:47];
    logic dat_v [0:47];
    logic oe_v [0:47];

    // Idle pins; the serial clock stands still low between frames
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        frame_sync_in = 1'b0;
        transfer_width_select = 1'b0;
        din = 1'b1;
    end

    // select and sync levels
    // Pins change just after the rising edge, so the falling edge sees them settled
    // clock rate is the master's; this bench runs a 30 ns period
    task automatic pulse(input logic c, input logic s, input logic d, input logic w, input int k);
        #15 sclk = 1'b1;
        #1;
        cs_n = c;
        frame_sync_in = s;
        din = d;
        transfer_width_select = w;
        #4;
        // Record only numbered clocks of a frame
        if (k >= 0 && k <= 47) begin
            fso_v[k] = frame_sync_out;
            str_v[k] = sample_strobe;
            dat_v[k] = dout;
            oe_v[k] = dout_oe_n;
        end
        #10 sclk = 1'b0;
    endtask

    // width, command, clock count
    // Unused data clocks toggle din, so a stale bit is never mistaken for a held one
    task automatic frame(input logic w, input logic [15:0] cmd, input int n);
        int nb;
        nb = w ? 16 : 8;
        pulse(1'b0, 1'b1, ~din, w, 0);
        for (int k = 1; k <= n; k++) begin
            pulse(1'b0, 1'b0, (k <= nb) ? cmd[nb-k] : ~din, w, k);
        end
    endtask
endmodule
